//--- mmd_core_model.sv
// Behavioural model of the core that issues program and data accesses.
`timescale 1ns/1ps
module mmd_core_model
	import mmd_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Request to the decoder.
	output mmd_req_t  req
);
	initial req = '0;

	// One access stands for one cycle. Afterwards valid is cleared, kind goes to AK_IDLE and the other fields are inverted,
	// so a decoder that reads a dropped request shows a wrong result instead of a lucky match.
	task automatic issue(input mmd_kind_t k, input logic w, input logic [15:0] a, input logic [1:0] b,
			input logic f);
		@(posedge clk_sys);
		req <= '{valid: resetn, kind: k, write: w, addr: a, bank: b, flash_wr_en: f};
		@(posedge clk_sys);
		req <= '{valid: 1'b0, kind: AK_IDLE, write: ~w, addr: ~a, bank: ~b, flash_wr_en: ~f};
	endtask : issue
endmodule : mmd_core_model

//--- mmd_data_dec.sv
// Combinational decoder of the internal data space.
`timescale 1ns/1ps
module mmd_data_dec
	import mmd_pkg::*;
(
	// Request.
	input  wire logic [7:0]    addr,
	input  wire mmd_kind_t     kind,
	input  wire logic [1:0]    bank,
	// Result.
	output mmd_data_tgt_t      tgt,
	output logic [7:0]         byte_addr,
	output logic [2:0]         bit_sel
);

	always_comb begin
		tgt       = DT_NONE;
		byte_addr = addr;
		bit_sel   = 3'h0;
		case (kind)
			AK_DIR, AK_IND: begin
				if (addr <= BANK_LAST) begin
					tgt       = DT_BANK;
					byte_addr = {3'h0, bank, addr[2:0]};
				end else if (addr >= BIT_FIRST && addr <= BIT_LAST) begin
					tgt = DT_BITAREA;
				end else if (addr < UPPER_FIRST) begin
					tgt = DT_LOWER;
				end else if (kind == AK_DIR) begin
					tgt = DT_SPECIAL;
				end else begin
					tgt = DT_UPPER;
				end
			end
			AK_BIT: begin
				// Bit addresses below 0x80 map to the 16-byte bit area.
				if (addr < UPPER_FIRST) begin
					tgt       = DT_BITAREA;
					byte_addr = BIT_FIRST + {4'h0, addr[6:3]};
					bit_sel   = addr[2:0];
				end else begin
					tgt = DT_SPECIAL;
				end
			end
			default: begin
				tgt = DT_NONE;
			end
		endcase
	end

endmodule : mmd_data_dec

//--- mmd_decoder.sv
// Top of the program and data memory map decoder.
`timescale 1ns/1ps
module mmd_decoder
	import mmd_pkg::*;
#(
	parameter int FLASH_KB = FLASH_KB_8
)(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Core request.
	input  wire mmd_req_t   req,
	// Routed access.
	output mmd_route_t      route,
	output logic            lock_hit
);

	//--------------------------------------------------------------------------
	// Parameter check
	//--------------------------------------------------------------------------
	if (FLASH_KB != FLASH_KB_8 && FLASH_KB != FLASH_KB_4 && FLASH_KB != FLASH_KB_2) begin : g_bad_size
		$error("FLASH_KB must be 8, 4 or 2");
	end
	if (RAM_TOTAL != 2 * IRAM_SIZE) begin : g_bad_ram
		$error("RAM split must be two equal halves");
	end
	// Expanded RAM must fill exactly the half of the array that internal RAM leaves free.
	if (RAM_TOTAL - IRAM_SIZE != 2 ** EXPANDED_ONCHIP_RAM_AW) begin : g_bad_expanded_onchip_ram
		$error("expanded RAM width does not match the RAM split");
	end

	localparam logic [15:0] FLASH_TOP = (FLASH_KB == FLASH_KB_8) ? FLASH_TOP_8K :
		(FLASH_KB == FLASH_KB_4) ? FLASH_TOP_4K : FLASH_TOP_2K;

	//--------------------------------------------------------------------------
	// Program space decode
	//--------------------------------------------------------------------------
	mmd_prog_tgt_t prog_next;

	// Code reads and steered writes decode the full 16-bit address, so every one of the 64 kB answers; other moves go to expanded RAM.
	always_comb begin
		prog_next = PT_NONE;
		case (req.kind)
			AK_FETCH, AK_CODE: begin
				// Code reads ignore the steering bit entirely.
				if (req.addr < FLASH_TOP) begin
					prog_next = PT_FLASH;
				end else if (req.addr == FLASH_TOP) begin
					prog_next = PT_LOCK;
				end else begin
					prog_next = PT_RESERVED;
				end
			end
			AK_XDATA: begin
				if (req.write && req.flash_wr_en) begin
					if (req.addr < FLASH_TOP) begin
						prog_next = PT_FLASH_WR;
					end else if (req.addr == FLASH_TOP) begin
						prog_next = PT_LOCK;
					end else begin
						prog_next = PT_RESERVED;
					end
				end else begin
					prog_next = PT_EXPANDED_ONCHIP_RAM;
				end
			end
			default: begin
				prog_next = PT_NONE;
			end
		endcase
	end

	//--------------------------------------------------------------------------
	// Data space decode
	//--------------------------------------------------------------------------
	mmd_data_tgt_t data_tgt;
	logic [7:0]    data_byte;
	logic [2:0]    data_bit;

	mmd_data_dec u_data_dec (
		.addr      (req.addr[7:0]),
		.kind      (req.kind),
		.bank      (req.bank),
		.tgt       (data_tgt),
		.byte_addr (data_byte),
		.bit_sel   (data_bit)
	);

	// Expanded RAM sits in the upper half of the 512-byte array, internal RAM in the lower.
	logic [8:0] ram_next;
	always_comb begin
		ram_next = 9'h000;
		if (prog_next == PT_EXPANDED_ONCHIP_RAM) begin
			ram_next = {1'b1, req.addr[EXPANDED_ONCHIP_RAM_AW-1:0]};
		end else if (data_tgt != DT_NONE && data_tgt != DT_SPECIAL) begin
			ram_next = {1'b0, data_byte};
		end
	end

	//--------------------------------------------------------------------------
	// Registered outputs
	//--------------------------------------------------------------------------
	// Addresses follow the request even in idle cycles; consumers qualify them with valid, which keeps
	// the wide address paths free of gating.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			route <= '0;
		end else begin
			route.valid     <= req.valid;
			route.prog_tgt  <= req.valid ? prog_next : PT_NONE;
			route.data_tgt  <= req.valid ? data_tgt : DT_NONE;
			route.prog_addr <= req.addr;
			route.ram_addr  <= ram_next;
			route.bit_sel   <= data_bit;
			route.write     <= req.write;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lock_hit <= 1'b0;
		end else begin
			lock_hit <= req.valid && prog_next == PT_LOCK;
		end
	end

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_code_req;
		req.valid && (req.kind == AK_CODE || req.kind == AK_FETCH);
	endsequence

	sequence s_steered_write;
		req.valid && req.kind == AK_XDATA && req.write && req.flash_wr_en;
	endsequence

	sequence s_data_req;
		req.valid && (req.kind == AK_DIR || req.kind == AK_IND);
	endsequence

	sequence s_bit_req;
		req.valid && req.kind == AK_BIT;
	endsequence

	//--------------------------------------------------------------------------
	// Program space checks
	//--------------------------------------------------------------------------
	a_code_in_flash: assert property (s_code_req ##0 (req.addr < FLASH_TOP) |=> route.prog_tgt == PT_FLASH)
		else $error("code read below lock byte not routed to flash");
	a_lock_byte_hit: assert property (s_code_req ##0 (req.addr == FLASH_TOP) |=> lock_hit && route.prog_tgt == PT_LOCK)
		else $error("lock byte not flagged");
	a_reserved_high: assert property (s_code_req ##0 (req.addr > FLASH_TOP) |=> route.prog_tgt == PT_RESERVED)
		else $error("address above lock byte not reserved");
	a_code_steer_free: assert property (s_code_req
		|=> route.prog_tgt != PT_FLASH_WR && route.prog_tgt != PT_EXPANDED_ONCHIP_RAM)
		else $error("code read followed the external-data steering");
	a_code_no_data: assert property (s_code_req
		|=> route.data_tgt == DT_NONE)
		else $error("code read reached the data map");
	a_xdata_steer: assert property (s_steered_write ##0 (req.addr < FLASH_TOP)
		|=> route.prog_tgt == PT_FLASH_WR)
		else $error("steered write not sent to flash");
	a_steer_lock: assert property (s_steered_write ##0 (req.addr == FLASH_TOP)
		|=> lock_hit && route.prog_tgt == PT_LOCK)
		else $error("steered write to lock byte not flagged");
	a_steer_reserved: assert property (s_steered_write ##0 (req.addr > FLASH_TOP)
		|=> route.prog_tgt == PT_RESERVED)
		else $error("steered write above lock byte not reserved");
	a_xdata_ram: assert property (req.valid && req.kind == AK_XDATA && !(req.write && req.flash_wr_en)
		|=> route.prog_tgt == PT_EXPANDED_ONCHIP_RAM && route.ram_addr[8] && route.ram_addr[7:0] == $past(req.addr[7:0]))
		else $error("external-data move not sent to expanded RAM");
	a_expanded_onchip_ram_half: assert property (route.prog_tgt == PT_EXPANDED_ONCHIP_RAM |-> route.ram_addr[8])
		else $error("expanded RAM access outside the upper half of the array");
	a_prog_addr_full: assert property (req.valid
		|=> route.prog_addr == $past(req.addr))
		else $error("program address not passed on in full");
	a_lock_only_top: assert property (lock_hit
		|-> route.prog_tgt == PT_LOCK && route.prog_addr == FLASH_TOP)
		else $error("lock flag raised away from the lock byte");
	a_idle_clear: assert property (!req.valid
		|=> route.prog_tgt == PT_NONE && route.data_tgt == DT_NONE && !lock_hit)
		else $error("idle cycle produced a target");

	//--------------------------------------------------------------------------
	// Data space checks
	//--------------------------------------------------------------------------
	a_bank_addr: assert property (req.valid && req.kind == AK_DIR && req.addr[7:0] <= BANK_LAST
		|=> route.ram_addr == {4'h0, $past(req.bank), $past(req.addr[2:0])})
		else $error("bank register address wrong");
	a_bank_indirect: assert property (s_data_req ##0 (req.kind == AK_IND && req.addr[7:0] <= BANK_LAST)
		|=> route.data_tgt == DT_BANK && route.ram_addr == {4'h0, $past(req.bank), $past(req.addr[2:0])})
		else $error("indirect bank register address wrong");
	a_bitarea_byte: assert property (s_data_req ##0 (req.addr[7:0] >= BIT_FIRST && req.addr[7:0] <= BIT_LAST)
		|=> route.data_tgt == DT_BITAREA && route.ram_addr == {1'b0, $past(req.addr[7:0])})
		else $error("byte access to bit area misrouted");
	a_bit_area: assert property (req.valid && req.kind == AK_BIT && !req.addr[7]
		|=> route.data_tgt == DT_BITAREA && route.ram_addr[7:4] == 4'h2)
		else $error("bit address not in bit area");
	a_bit_select: assert property (s_bit_req ##0 !req.addr[7]
		|=> route.bit_sel == $past(req.addr[2:0]) && route.ram_addr[3:0] == $past(req.addr[6:3]))
		else $error("bit address split wrong");
	a_bit_upper: assert property (s_bit_req ##0 req.addr[7]
		|=> route.data_tgt == DT_SPECIAL)
		else $error("upper bit address not sent to special space");
	a_direct_upper: assert property (req.valid && req.kind == AK_DIR && req.addr[7]
		|=> route.data_tgt == DT_SPECIAL)
		else $error("direct upper access not sent to special space");
	a_indirect_upper: assert property (req.valid && req.kind == AK_IND && req.addr[7]
		|=> route.data_tgt == DT_UPPER && route.ram_addr == {1'b0, $past(req.addr[7:0])})
		else $error("indirect upper access not sent to upper RAM");
	a_lower_both: assert property (req.valid && (req.kind == AK_DIR || req.kind == AK_IND)
		&& req.addr[7:0] > BIT_LAST && !req.addr[7] |=> route.data_tgt == DT_LOWER)
		else $error("lower scratch access misrouted");
	a_iram_half: assert property (route.data_tgt inside {DT_BANK, DT_BITAREA, DT_LOWER, DT_UPPER} |-> !route.ram_addr[8])
		else $error("internal RAM access outside the lower half of the array");
	a_data_no_prog: assert property (s_data_req
		|=> route.prog_tgt == PT_NONE && !lock_hit)
		else $error("data access reached the program map");

endmodule : mmd_decoder

//--- mmd_pkg.sv
// Package of constants and carrier types for the memory map decoder.
//------------------------------------------------------------------------------
// Functional notes
// - The program address space seen by the core is 64 kB wide, whatever part of it holds Flash.
// - Flash is one block from 0x0000 up to 0x1FFF, 0x0FFF or 0x07FF for the 8, 4 or 2 kB variant.
// - The top byte of the implemented Flash block is the security lock byte, not program storage.
// - Program addresses above the lock byte up to the top of the space decode as reserved.
// - External-data moves go to expanded RAM, but their writes go to Flash write/erase when enabled.
// - Code-memory reads go to Flash, the lock byte or reserved by address alone, whatever the external-data move steering says.
// - Data RAM totals 512 bytes: 256 bytes internal RAM, the rest expanded RAM.
// - Internal RAM answers data addresses 0x00 through 0xFF.
// - The lower 128 bytes of internal RAM are reached by both direct and indirect modes.
// - Addresses 0x00 to 0x1F are four banks of eight byte registers, chosen by the bank select.
// - Bytes 0x20 to 0x2F are reachable as bytes or as 128 direct-addressed bits.
// - The upper 128 bytes are reachable only indirectly and are separate from the special space.
//------------------------------------------------------------------------------
package mmd_pkg;

	localparam int        PROG_AW        = 16;
	localparam int        DATA_AW        = 8;
	localparam int        EXPANDED_ONCHIP_RAM_AW        = 8;
	localparam int        FLASH_KB_8     = 8;
	localparam int        FLASH_KB_4     = 4;
	localparam int        FLASH_KB_2     = 2;
	localparam logic [15:0] FLASH_BASE   = 16'h0000;
	localparam logic [15:0] FLASH_TOP_8K = 16'h1fff;
	localparam logic [15:0] FLASH_TOP_4K = 16'h0fff;
	localparam logic [15:0] FLASH_TOP_2K = 16'h07ff;
	localparam int        RAM_TOTAL      = 512;
	localparam int        IRAM_SIZE      = 256;
	localparam logic [7:0] BANK_LAST     = 8'h1f;
	localparam logic [7:0] BIT_FIRST     = 8'h20;
	localparam logic [7:0] BIT_LAST      = 8'h2f;
	localparam logic [7:0] UPPER_FIRST   = 8'h80;
	localparam int        BANK_REGS      = 8;

	// Where a program-side access lands.
	typedef enum logic [2:0] {
		PT_NONE     = 3'b000,
		PT_FLASH    = 3'b001,
		PT_LOCK     = 3'b010,
		PT_RESERVED = 3'b011,
		PT_FLASH_WR = 3'b100,
		PT_EXPANDED_ONCHIP_RAM     = 3'b101
	} mmd_prog_tgt_t;

	// Where a data-side access lands.
	typedef enum logic [2:0] {
		DT_NONE    = 3'b000,
		DT_BANK    = 3'b001,
		DT_BITAREA = 3'b010,
		DT_LOWER   = 3'b011,
		DT_UPPER   = 3'b100,
		DT_SPECIAL = 3'b101
	} mmd_data_tgt_t;

	// Access kinds issued by the core.
	typedef enum logic [2:0] {
		AK_IDLE  = 3'b000,
		AK_FETCH = 3'b001,
		AK_CODE  = 3'b010,
		AK_XDATA = 3'b011,
		AK_DIR   = 3'b100,
		AK_IND   = 3'b101,
		AK_BIT   = 3'b110
	} mmd_kind_t;

	typedef struct packed {
		logic             valid;
		mmd_kind_t        kind;
		logic             write;
		logic [15:0]      addr;
		logic [1:0]       bank;
		logic             flash_wr_en;
	} mmd_req_t;

	typedef struct packed {
		logic             valid;
		mmd_prog_tgt_t    prog_tgt;
		mmd_data_tgt_t    data_tgt;
		logic [15:0]      prog_addr;
		logic [8:0]       ram_addr;
		logic [2:0]       bit_sel;
		logic             write;
	} mmd_route_t;

endpackage : mmd_pkg

//--- tb_mmd_decoder.sv
// Self-checking testbench of the memory map decoder.
`timescale 1ns/1ps
module tb_mmd_decoder
	import mmd_pkg::*;
;
	logic       clk_sys;
	logic       resetn;
	mmd_req_t   req;
	mmd_route_t route;
	logic       lock_hit;
	int         miscompares;
	int         compares;

	mmd_core_model i_mmd_core_model (.clk_sys(clk_sys), .resetn(resetn), .req(req));
	mmd_decoder #(.FLASH_KB(FLASH_KB_8)) i_mmd_decoder (.clk_sys(clk_sys), .resetn(resetn), .req(req),
		.route(route), .lock_hit(lock_hit));

	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	task automatic note_bad(input string msg);
		miscompares++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask : note_bad

	// Program-side access, judged one cycle later.
	task automatic prog(input mmd_kind_t k, input logic w, input logic [15:0] a, input logic f,
			input mmd_prog_tgt_t t, input logic lk);
		i_mmd_core_model.issue(k, w, a, 2'h0, f);
		#1;
		compares++;
		if (route.prog_tgt !== t || lock_hit !== lk || route.data_tgt !== DT_NONE || route.valid !== 1'b1 ||
				route.write !== w ||
				route.prog_addr !== a || (t == PT_EXPANDED_ONCHIP_RAM && route.ram_addr !== {1'b1, a[7:0]}))
			note_bad($sformatf("program access %h gave %s", a, route.prog_tgt.name()));
	endtask : prog

	// Data-side access, judged one cycle later.
	task automatic data(input mmd_kind_t k, input logic [7:0] a, input logic [1:0] b,
			input mmd_data_tgt_t t, input logic [8:0] ram, input logic [2:0] bs);
		i_mmd_core_model.issue(k, 1'b0, {8'h00, a}, b, 1'b0);
		#1;
		compares++;
		if (route.data_tgt !== t || route.prog_tgt !== PT_NONE || lock_hit !== 1'b0 ||
				route.valid !== 1'b1 || route.write !== 1'b0 ||
				(t != DT_SPECIAL && route.ram_addr !== ram) || (t == DT_BITAREA && route.bit_sel !== bs))
			note_bad($sformatf("data access %h gave %s at %h", a, route.data_tgt.name(), route.ram_addr));
	endtask : data

	// An idle cycle right after an access must show no target.
	task automatic idle_after();
		@(posedge clk_sys);
		#1;
		compares++;
		if (route.prog_tgt !== PT_NONE || route.data_tgt !== DT_NONE || lock_hit !== 1'b0)
			note_bad("idle cycle kept a target");
	endtask : idle_after

	task automatic sc_reset();
		#1;
		compares++;
		if (route !== '0 || lock_hit !== 1'b0)
			note_bad("outputs not cleared in reset");
	endtask : sc_reset

	task automatic sc_program();
		prog(AK_FETCH, 1'b0, 16'h0000, 1'b0, PT_FLASH, 1'b0);
		prog(AK_FETCH, 1'b0, 16'h1ffe, 1'b0, PT_FLASH, 1'b0);
		prog(AK_FETCH, 1'b0, 16'h1fff, 1'b0, PT_LOCK, 1'b1);
		idle_after();
		prog(AK_CODE, 1'b0, 16'h1fff, 1'b0, PT_LOCK, 1'b1);
		prog(AK_FETCH, 1'b0, 16'h2000, 1'b0, PT_RESERVED, 1'b0);
		prog(AK_CODE, 1'b0, 16'hffff, 1'b0, PT_RESERVED, 1'b0);
	endtask : sc_program

	task automatic sc_xdata();
		prog(AK_XDATA, 1'b0, 16'h0042, 1'b0, PT_EXPANDED_ONCHIP_RAM, 1'b0);
		prog(AK_XDATA, 1'b1, 16'h00ff, 1'b0, PT_EXPANDED_ONCHIP_RAM, 1'b0);
		prog(AK_XDATA, 1'b1, 16'h0100, 1'b1, PT_FLASH_WR, 1'b0);
		prog(AK_XDATA, 1'b0, 16'h0000, 1'b1, PT_EXPANDED_ONCHIP_RAM, 1'b0);
		prog(AK_CODE, 1'b0, 16'h0100, 1'b1, PT_FLASH, 1'b0);
		prog(AK_XDATA, 1'b1, 16'h1fff, 1'b1, PT_LOCK, 1'b1);
		prog(AK_XDATA, 1'b1, 16'h8000, 1'b1, PT_RESERVED, 1'b0);
	endtask : sc_xdata

	task automatic sc_internal();
		data(AK_DIR, 8'h05, 2'h2, DT_BANK, 9'h015, 3'h0);
		data(AK_IND, 8'h1f, 2'h3, DT_BANK, 9'h01f, 3'h0);
		data(AK_DIR, 8'h00, 2'h0, DT_BANK, 9'h000, 3'h0);
		data(AK_DIR, 8'h7f, 2'h0, DT_LOWER, 9'h07f, 3'h0);
		data(AK_IND, 8'h30, 2'h0, DT_LOWER, 9'h030, 3'h0);
		data(AK_DIR, 8'h2a, 2'h0, DT_BITAREA, 9'h02a, 3'h0);
		data(AK_IND, 8'h2f, 2'h1, DT_BITAREA, 9'h02f, 3'h0);
	endtask : sc_internal

	task automatic sc_bits();
		data(AK_BIT, 8'h0a, 2'h0, DT_BITAREA, 9'h021, 3'h2);
		data(AK_BIT, 8'h00, 2'h0, DT_BITAREA, 9'h020, 3'h0);
		data(AK_BIT, 8'h7f, 2'h0, DT_BITAREA, 9'h02f, 3'h7);
		data(AK_BIT, 8'h88, 2'h0, DT_SPECIAL, 9'h000, 3'h0);
	endtask : sc_bits

	task automatic sc_upper();
		data(AK_DIR, 8'h90, 2'h0, DT_SPECIAL, 9'h000, 3'h0);
		data(AK_IND, 8'h90, 2'h0, DT_UPPER, 9'h090, 3'h0);
		data(AK_IND, 8'hff, 2'h0, DT_UPPER, 9'h0ff, 3'h0);
		data(AK_DIR, 8'h80, 2'h0, DT_SPECIAL, 9'h000, 3'h0);
		data(AK_IND, 8'h80, 2'h0, DT_UPPER, 9'h080, 3'h0);
	endtask : sc_upper

	// Reset in mid-run must clear the stale addresses at once, and the next access must decode normally.
	task automatic sc_mid_reset();
		@(posedge clk_sys);
		resetn <= 1'b0;
		#1;
		compares++;
		if (route !== '0 || lock_hit !== 1'b0)
			note_bad("outputs not cleared by reset in mid-run");
		@(posedge clk_sys);
		resetn <= 1'b1;
		prog(AK_FETCH, 1'b0, 16'h1fff, 1'b0, PT_LOCK, 1'b1);
	endtask : sc_mid_reset

	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// A hang is cut short here; nothing in the flow waits on the design.
	initial begin
		repeat (4000) @(posedge clk_sys);
		note_bad("run did not finish");
		stop_test();
	end

	initial begin
		resetn = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (8) @(posedge clk_sys);
		sc_reset();
		@(posedge clk_sys);
		resetn <= 1'b1;
		sc_program();
		sc_xdata();
		sc_internal();
		sc_bits();
		sc_upper();
		sc_mid_reset();
		stop_test();
	end
endmodule : tb_mmd_decoder
